/* File: logic/mute_switch_map.svh */
// timing counts and reset values for the mute delay and switch control block
`ifndef MUTE_SWITCH_MAP_SVH
`define MUTE_SWITCH_MAP_SVH

`define CLK_PERIOD_PS      4000
`define DEGLITCH_TIME_NS   16000
`define DEGLITCH_CYCLES    ((`DEGLITCH_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PFM_ENTRY_CYCLES   2048
`define MUTE_TRANSITIONS   10
`define HOT_CLEAR_COUNTS   15

`define DEGLITCH_W         12
`define PFM_W              12
`define MUTE_W             4
`define HOT_W              4

`define RST_BIT            1'b0
`define ONE_BIT            1'b1

`endif

/* File: logic/mute_switch_pkg.sv */
// types shared by the mute delay and switch control block
`default_nettype none

package mute_switch_pkg;

    // detector inputs as seen by the digital core
    typedef struct packed {
        logic battery_cmp;
        logic ignition_cmp;
        logic cap_at_high;
        logic cap_at_low;
    } detect_in_s;

    // protection and control inputs
    typedef struct packed {
        logic switch_enable_input;
        logic enable_sync;
        logic switch_supply_ov;
        logic thermal_trip_low;
        logic thermal_trip_high;
    } ctrl_in_s;

    typedef enum logic { CAP_SEEK_HIGH, CAP_SEEK_LOW } cap_phase_e;

    typedef struct packed {
        logic [1:0]  switch_on;
        logic        regulators_off;
        logic        pfm_mode;
        logic        battery_out;
        logic        ignition_out;
        logic        mute_oe_n;
        logic        mute_active;
        logic [11:0] deglitch_cnt;
        logic [11:0] pfm_cnt;
        logic [3:0]  mute_cnt;
        logic [3:0]  hot_clear_cnt;
        cap_phase_e  cap_phase;
        logic        trip_low_latch;
        logic        trip_high_latch;
    } state_s;

endpackage : mute_switch_pkg

`default_nettype wire

/* File: logic/mute_delay_and_switch_control.sv */
// mute delay timer, always-on regulator mode entry and high-side switch control
`timescale 1ns/1ps
`default_nettype none
`include "mute_switch_map.svh"

// Operation
// R1: both switches follow the one enable together
// R2: supply overvoltage forces both switches off
// R3: PFM after enable and ignition low 2048
// R4: ignition high returns to PWM at once; code holds PFM while the high trip latch is set
// R5: mute is open-drain, active low output
// R6: battery change mutes for ten capacitor swings
// R7: battery change mid-interval restarts count at zero
// R8: battery result deglitched, short pulses ignored
// R9: thermal trips never touch the mute timer
// R10: battery and ignition decisions on own pins
// R11: low trip latches switches, cleared by enable low
// R12: high trip latches off, cleared 15 counts low
// R13: mute released on the terminal-count cycle
module mute_delay_and_switch_control #(
    parameter int unsigned DEGLITCH_CYCLES  = `DEGLITCH_CYCLES,
    parameter int unsigned PFM_ENTRY_CYCLES = `PFM_ENTRY_CYCLES,
    parameter int unsigned MUTE_TRANSITIONS = `MUTE_TRANSITIONS,
    parameter int unsigned HOT_CLEAR_COUNTS = `HOT_CLEAR_COUNTS
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    // detector and timing capacitor comparators
    input  wire mute_switch_pkg::detect_in_s detect_in,
    // enables and protection detectors
    input  wire mute_switch_pkg::ctrl_in_s   ctrl_in,
    // high-side switch drive
    output logic                          high_side_switch_a,
    output logic                          high_side_switch_b,
    // regulator control
    output logic                          always_on_regulator_pfm,
    output logic                          regulators_off,
    // comparator output pins
    output logic                          battery_compare_output,
    output logic                          ignition_compare_output,
    // open-drain mute pin
    output logic                          mute_out,
    output logic                          mute_oe_n,
    output logic                          mute_active
);

    // counters are 12 and 4 bits wide; refuse what does not fit
    generate
        if (DEGLITCH_CYCLES < 1 || DEGLITCH_CYCLES >= (1 << `DEGLITCH_W))
        begin : g_bad_deglitch
            $error("deglitch count out of range");
        end
        if (PFM_ENTRY_CYCLES < 1 || PFM_ENTRY_CYCLES >= (1 << `PFM_W))
        begin : g_bad_pfm
            $error("pfm entry count out of range");
        end
        if (MUTE_TRANSITIONS < 1 || MUTE_TRANSITIONS >= (1 << `MUTE_W))
        begin : g_bad_mute
            $error("mute transition count out of range");
        end
        if (HOT_CLEAR_COUNTS < 1 || HOT_CLEAR_COUNTS >= (1 << `HOT_W))
        begin : g_bad_hot
            $error("hot clear count out of range");
        end
    endgenerate

    localparam logic [`DEGLITCH_W-1:0] DEGLITCH_LAST = `DEGLITCH_W'(DEGLITCH_CYCLES - 1);
    localparam logic [`PFM_W-1:0]      PFM_LAST      = `PFM_W'(PFM_ENTRY_CYCLES - 1);
    localparam logic [`MUTE_W-1:0]     MUTE_LAST     = `MUTE_W'(MUTE_TRANSITIONS - 1);
    localparam logic [`HOT_W-1:0]      HOT_LAST      = `HOT_W'(HOT_CLEAR_COUNTS - 1);

    mute_switch_pkg::state_s state_reg;
    mute_switch_pkg::state_s state_next;

    logic battery_change;
    logic cap_transition;
    logic switch_allowed;

    // saturating increment used by the pfm and hot-clear run-length counters
    function automatic logic [11:0] sat_inc(input logic [11:0] v, input logic [11:0] last);
        sat_inc = (v >= last) ? last : v + 12'h001;
    endfunction

    always_comb
    begin
        state_next     = state_reg;
        battery_change = `RST_BIT;
        cap_transition = `RST_BIT;

        // battery deglitch: accept a new level only after it held the full window
        if (detect_in.battery_cmp == state_reg.battery_out)
        begin
            state_next.deglitch_cnt = '0; // see R8
        end
        else if (state_reg.deglitch_cnt == DEGLITCH_LAST)
        begin
            state_next.deglitch_cnt = '0;
            state_next.battery_out  = detect_in.battery_cmp; // see R8 see R10
            battery_change          = `ONE_BIT;
        end
        else
        begin
            state_next.deglitch_cnt = state_reg.deglitch_cnt + 12'h001;
        end

        // ignition decision passes straight to its own pin
        state_next.ignition_out = detect_in.ignition_cmp; // see R10

        // a swing completes when the cap reaches the threshold it was heading for
        case (state_reg.cap_phase)
            mute_switch_pkg::CAP_SEEK_HIGH:
            begin
                if (detect_in.cap_at_high)
                begin
                    state_next.cap_phase = mute_switch_pkg::CAP_SEEK_LOW;
                    cap_transition       = `ONE_BIT;
                end
            end
            mute_switch_pkg::CAP_SEEK_LOW:
            begin
                if (detect_in.cap_at_low)
                begin
                    state_next.cap_phase = mute_switch_pkg::CAP_SEEK_HIGH;
                    cap_transition       = `ONE_BIT;
                end
            end
            default:
            begin
                state_next.cap_phase = mute_switch_pkg::CAP_SEEK_HIGH;
            end
        endcase

        // mute timer; thermal inputs are deliberately absent here
        if (battery_change)
        begin
            // a change wins over a terminal count in the same cycle
            state_next.mute_active = `ONE_BIT; // see R6 see R7 see R9
            state_next.mute_cnt    = '0;       // see R7
        end
        else if (state_reg.mute_active && cap_transition)
        begin
            if (state_reg.mute_cnt == MUTE_LAST)
            begin
                state_next.mute_active = `RST_BIT; // see R13
                state_next.mute_cnt    = '0;
            end
            else
            begin
                state_next.mute_cnt = state_reg.mute_cnt + 4'h1; // see R6
            end
        end
        state_next.mute_oe_n = ~state_next.mute_active; // see R5

        // low thermal latch: trip wins over the clear
        if (ctrl_in.thermal_trip_low)
        begin
            state_next.trip_low_latch = `ONE_BIT; // see R11
        end
        else if (!ctrl_in.switch_enable_input)
        begin
            state_next.trip_low_latch = `RST_BIT; // see R11
        end

        // high thermal latch clears after enable/sync held low long enough
        if (ctrl_in.enable_sync || ctrl_in.thermal_trip_high)
        begin
            state_next.hot_clear_cnt = '0;
        end
        else
        begin
            state_next.hot_clear_cnt = `HOT_W'(sat_inc({8'h00, state_reg.hot_clear_cnt},
                                                       {8'h00, HOT_LAST}));
        end
        if (ctrl_in.thermal_trip_high)
        begin
            state_next.trip_high_latch = `ONE_BIT; // see R12
        end
        else if (!ctrl_in.enable_sync && state_reg.hot_clear_cnt == HOT_LAST)
        begin
            state_next.trip_high_latch = `RST_BIT; // see R12
        end
        state_next.regulators_off = state_next.trip_high_latch; // see R12

        // always-on regulator mode
        if (detect_in.ignition_cmp || ctrl_in.enable_sync)
        begin
            state_next.pfm_cnt  = '0;
            state_next.pfm_mode = state_next.trip_high_latch; // see R4
        end
        else
        begin
            state_next.pfm_cnt = sat_inc(state_reg.pfm_cnt, PFM_LAST);
            // a latch-forced low power mode ends with the latch unless the low run is complete
            state_next.pfm_mode = (state_reg.pfm_cnt == PFM_LAST)
                                | state_next.trip_high_latch; // see R3
        end

        // both switches share one on/off decision
        switch_allowed = ctrl_in.switch_enable_input      // see R1
                       & ~ctrl_in.switch_supply_ov        // see R2
                       & ~state_next.trip_low_latch       // see R11
                       & ~state_next.trip_high_latch;     // see R12
        for (int i = 0; i < 2; i++)
        begin
            state_next.switch_on[i] = switch_allowed; // see R1
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg           <= '0;
            state_reg.mute_oe_n <= `ONE_BIT;
            state_reg.cap_phase <= mute_switch_pkg::CAP_SEEK_HIGH;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign high_side_switch_a      = state_reg.switch_on[0];
    assign high_side_switch_b      = state_reg.switch_on[1];
    assign always_on_regulator_pfm = state_reg.pfm_mode;
    assign regulators_off          = state_reg.regulators_off;
    assign battery_compare_output  = state_reg.battery_out;
    assign ignition_compare_output = state_reg.ignition_out;
    // open drain only ever pulls low
    assign mute_out                = `RST_BIT;
    assign mute_oe_n               = state_reg.mute_oe_n;
    assign mute_active             = state_reg.mute_active;

endmodule // mute_delay_and_switch_control

`default_nettype wire

/* File: tb/mute_switch_chk.sv */
// port assertions for the mute delay and switch control block
`timescale 1ns/1ps
`default_nettype none
module mute_switch_chk #(
    parameter int unsigned DEGLITCH_CYCLES  = 8,
    parameter int unsigned PFM_ENTRY_CYCLES = 16
) (
    // clock, reset and inputs
    input wire logic                        clk_sys,
    input wire logic                        arst_n,
    input wire mute_switch_pkg::detect_in_s detect_in,
    input wire mute_switch_pkg::ctrl_in_s   ctrl_in,
    // outputs of the block
    input wire logic high_side_switch_a,
    input wire logic high_side_switch_b,
    input wire logic always_on_regulator_pfm,
    input wire logic regulators_off,
    input wire logic battery_compare_output,
    input wire logic ignition_compare_output,
    input wire logic mute_out,
    input wire logic mute_oe_n,
    input wire logic mute_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [11:0] low_reg;
    logic [11:0] dif_reg;
    // saturating run lengths, so long idle spells never wrap
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_reg <= 12'h000;
            dif_reg <= 12'h000;
        end
        else
        begin
            low_reg <= (detect_in.ignition_cmp | ctrl_in.enable_sync) ? 12'h000
                       : low_reg + {11'h000, ~&low_reg};
            dif_reg <= (detect_in.battery_cmp == battery_compare_output) ? 12'h000
                       : dif_reg + {11'h000, ~&dif_reg};
        end
    end
    chk_switch_pair: assert property (high_side_switch_a == high_side_switch_b)
        else $error("switches differ");
    chk_enable_off: assert property (!ctrl_in.switch_enable_input |=> !high_side_switch_a)
        else $error("switch on without enable");
    chk_ov_off: assert property (ctrl_in.switch_supply_ov |=> !high_side_switch_a)
        else $error("switch on in overvoltage");
    chk_low_latch: assert property (ctrl_in.thermal_trip_low ##1 ctrl_in.switch_enable_input
        |=> !high_side_switch_a) else $error("low trip latch not held");
    chk_hot_latch: assert property (ctrl_in.thermal_trip_high
        |=> regulators_off && always_on_regulator_pfm) else $error("high trip not latched");
    chk_pfm_wait: assert property ($rose(always_on_regulator_pfm) && !regulators_off
        |-> low_reg >= PFM_ENTRY_CYCLES) else $error("low power mode too early");
    chk_pfm_exit: assert property (detect_in.ignition_cmp && !ctrl_in.thermal_trip_high
        && !regulators_off |=> !always_on_regulator_pfm) else $error("pwm not restored");
    chk_deglitch_len: assert property ($changed(battery_compare_output)
        |-> dif_reg >= DEGLITCH_CYCLES) else $error("battery glitch passed");
    chk_mute_start: assert property ($changed(battery_compare_output) |-> mute_active)
        else $error("no mute on battery change");
    chk_mute_pin: assert property (mute_active != mute_oe_n && !mute_out)
        else $error("mute pin drive wrong");
endmodule // mute_switch_chk
`default_nettype wire

/* File: tb/cap_osc_model.sv */
// timing capacitor oscillator and mute pin pull-up
`timescale 1ns/1ps
`default_nettype none
module cap_osc_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // cycles between threshold crossings
    input  wire logic [3:0] period,
    // mute pin and cap thresholds
    input  wire logic       mute_oe_n,
    output logic            mute_pin,
    output logic            cap_at_high,
    output logic            cap_at_low
);
    logic [3:0] cnt_reg;
    logic       up_reg;
    // released pin rests at the pull-up level
    assign mute_pin  = mute_oe_n ? 1'h1 : 1'h0;
    assign cap_at_high = (cnt_reg == 4'h0) && up_reg;
    assign cap_at_low  = (cnt_reg == 4'h0) && !up_reg;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= 4'h0;
            up_reg  <= 1'h1;
        end
        else if (cnt_reg == 4'h0)
        begin
            cnt_reg <= period - 4'h1;
            up_reg  <= !up_reg;
        end
        else
            cnt_reg <= cnt_reg - 4'h1;
    end
endmodule // cap_osc_model
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the mute delay and switch control block
`timescale 1ns/1ps
`default_nettype none
bind mute_delay_and_switch_control mute_switch_chk #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES),
    .PFM_ENTRY_CYCLES(PFM_ENTRY_CYCLES)) mute_switch_chk_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .detect_in(detect_in), .ctrl_in(ctrl_in),
    .high_side_switch_a(high_side_switch_a), .high_side_switch_b(high_side_switch_b),
    .always_on_regulator_pfm(always_on_regulator_pfm), .regulators_off(regulators_off),
    .battery_compare_output(battery_compare_output),
    .ignition_compare_output(ignition_compare_output), .mute_out(mute_out),
    .mute_oe_n(mute_oe_n), .mute_active(mute_active));
module testbench;
    localparam int unsigned DEG = 8;
    localparam int unsigned PFM = 16;
    localparam int unsigned P   = 4;
    logic                      clk_sys = 1'h0;
    logic                      arst_n  = 1'h0;
    logic                      bat     = 1'h0;
    logic                      ign     = 1'h1;
    logic                      ch, cl, mpin, sw_a, sw_b, pfm, roff, bout, iout, mo, moe_n, mact;
    mute_switch_pkg::ctrl_in_s ctrl    = '0;
    mute_switch_pkg::detect_in_s det;
    int                        num_errors = 0;
    int                        tests_run  = 0;
    assign det = '{bat, ign, ch, cl};
    always #2 clk_sys = ~clk_sys;
    mute_delay_and_switch_control #(.DEGLITCH_CYCLES(DEG), .PFM_ENTRY_CYCLES(PFM))
    mute_delay_and_switch_control_inst (.clk_sys(clk_sys), .arst_n(arst_n), .detect_in(det),
        .ctrl_in(ctrl), .high_side_switch_a(sw_a), .high_side_switch_b(sw_b),
        .always_on_regulator_pfm(pfm), .regulators_off(roff), .battery_compare_output(bout),
        .ignition_compare_output(iout), .mute_out(mo), .mute_oe_n(moe_n), .mute_active(mact));
    cap_osc_model cap_osc_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .period(4'(P)),
        .mute_oe_n(moe_n), .mute_pin(mpin), .cap_at_high(ch), .cap_at_low(cl));
    // inputs move 1 ns after the edge, clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic test_switch();
        ctrl.switch_enable_input = 1'h1;
        step(2);
        check(sw_a, 1'h1);
        check(sw_b, 1'h1);
        ctrl.switch_supply_ov = 1'h1;
        step(2);
        check(sw_a, 1'h0);
        ctrl.switch_supply_ov = 1'h0;
        ctrl.thermal_trip_low = 1'h1;
        step(1);
        ctrl.thermal_trip_low = 1'h0;
        step(3);
        check(sw_b, 1'h0);
        ctrl.switch_enable_input = 1'h0;
        step(2);
        ctrl.switch_enable_input = 1'h1;
        step(2);
        check(sw_a, 1'h1);
        $display("switch test done");
    endtask
    task automatic test_hot();
        ctrl.thermal_trip_high = 1'h1;
        step(1);
        ctrl.thermal_trip_high = 1'h0;
        step(2);
        check(roff, 1'h1);
        check(sw_a, 1'h0);
        ctrl.enable_sync = 1'h0;
        step(5);
        ctrl.enable_sync = 1'h1;
        step(2);
        check(roff, 1'h1);
        ctrl.enable_sync = 1'h0;
        step(18);
        check(roff, 1'h0);
        check(sw_a, 1'h1);
        $display("thermal test done");
    endtask
    task automatic test_pfm();
        ign = 1'h0;
        step(PFM - 2);
        check(pfm, 1'h0);
        step(6);
        check(pfm, 1'h1);
        check(iout, 1'h0);
        ign = 1'h1;
        step(1);
        check(pfm, 1'h0);
        check(iout, 1'h1);
        ctrl.enable_sync = 1'h1;
        $display("mode test done");
    endtask
    task automatic test_mute();
        bat = 1'h1;
        step(3);
        bat = 1'h0;
        step(12);
        check(bout, 1'h0);
        check(mact, 1'h0);
        bat = 1'h1;
        step(DEG + 2);
        check(bout, 1'h1);
        check(mpin, 1'h0);
        step(5 * P);
        bat = 1'h0;
        ctrl.thermal_trip_low = 1'h1;
        ctrl.thermal_trip_high = 1'h1;
        step(1);
        ctrl.thermal_trip_low = 1'h0;
        ctrl.thermal_trip_high = 1'h0;
        step(DEG + 8 * P - 1);
        check(mact, 1'h1);
        step(3 * P);
        check(mact, 1'h0);
        check(mpin, 1'h1);
        $display("mute test done");
    endtask
    initial
    begin
        ctrl.enable_sync = 1'h1;
        step(16);
        arst_n = 1'h1;
        step(2);
        test_switch();
        test_hot();
        test_pfm();
        test_mute();
        end_of_test();
    end
    initial
    begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
